// ### hw/mpi_prog.sv
`timescale 1ns/1ps
`default_nettype none
module mpi_prog
	import mpi_pkg::*;
#(
	parameter int WR_CYC = WR_CYC_DEF,
	parameter int CE_CYC = CE_CYC_DEF
)(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic prog_reset_n_i,
	input wire logic sck_i,
	input wire logic prog_serial_in_i,
	input wire logic par_wr_n_i,
	input wire logic [1:0] par_cmd_i,
	input wire logic [AW-1:0] par_addr_i,
	input wire logic [7:0] par_data_i,
	output logic prog_serial_out_o,
	output logic ready_busy_flag_o,
	output logic prog_enabled_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum {ST_IDLE, ST_WRITE, ST_ERASE, ST_WAIT} mpi_st_t;
	typedef struct packed {
		logic [1:0] rst_s, sck_s, sdi_s, wr_s;
		logic sck_d, wr_d;
		logic [7:0] sh_in, sh_out;
		logic [1:0] byte_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] b1, b2, b3;
		logic enabled;
		logic sdo;
		logic busy;
		mpi_st_t st;
		logic [AW-1:0] addr;
		logic [7:0] wdat;
		logic [17:0] tmr;
		logic [17:0] limit;
		logic [1:0] cmd_s0, cmd_s1;
		logic [AW-1:0] adr_s0, adr_s1;
		logic [7:0] dat_s0, dat_s1;
		logic rdy;
	} mpi_state_t;
	mpi_state_t s_r, s_nxt;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [7:0] mem_wdat, mem_rdat;

	mpi_mem u_mem (
		.core_clk_i(core_clk_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdat),
		.rdata_o(mem_rdat)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic rise, fall, wr_fall, in_prog;
		logic [7:0] nb;
		rise = s_r.sck_s[1] && !s_r.sck_d;
		fall = !s_r.sck_s[1] && s_r.sck_d;
		wr_fall = !s_r.wr_s[1] && s_r.wr_d;
		in_prog = !s_r.rst_s[1];
		nb = {s_r.sh_in[6:0], s_r.sdi_s[1]};
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_addr = s_r.addr;
		mem_wdat = s_r.wdat;
		s_nxt.rst_s = {s_r.rst_s[0], prog_reset_n_i};
		s_nxt.sck_s = {s_r.sck_s[0], sck_i};
		s_nxt.sdi_s = {s_r.sdi_s[0], prog_serial_in_i};
		s_nxt.wr_s = {s_r.wr_s[0], par_wr_n_i};
		// Command, address and data pass two flops like the strobe, so
		// they have settled by the time the strobe edge is seen.
		s_nxt.cmd_s0 = par_cmd_i;
		s_nxt.cmd_s1 = s_r.cmd_s0;
		s_nxt.adr_s0 = par_addr_i;
		s_nxt.adr_s1 = s_r.adr_s0;
		s_nxt.dat_s0 = par_data_i;
		s_nxt.dat_s1 = s_r.dat_s0;
		s_nxt.sck_d = s_r.sck_s[1];
		s_nxt.wr_d = s_r.wr_s[1];
		if (!in_prog) begin
			// Leaving programming drops the enable and resyncs the framer.
			s_nxt.enabled = 1'b0;
			s_nxt.bit_cnt = 3'h0;
			s_nxt.byte_cnt = 2'h0;
		end else if (rise) begin
			s_nxt.sh_in = nb;
			s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
			if (s_r.bit_cnt == 3'h7) begin
				s_nxt.byte_cnt = s_r.byte_cnt + 2'h1;
				unique case (s_r.byte_cnt)
					2'h0: s_nxt.b1 = nb;
					2'h1: begin
						s_nxt.b2 = nb;
						s_nxt.sh_out = nb;
					end
					2'h2: begin
						s_nxt.b3 = nb;
					end
					2'h3: begin
						if (s_r.b1 == OP_PREFIX && s_r.b2 == OP_ENABLE) begin
							s_nxt.enabled = 1'b1;
						end else if (s_r.enabled && s_r.st == ST_IDLE) begin
							if (s_r.b1 == OP_PREFIX
								&& s_r.b2[7:5] == OP_ERASE_TOP) begin
								s_nxt.st = ST_ERASE;
								s_nxt.addr = '0;
								s_nxt.limit = 18'(CE_CYC);
								s_nxt.tmr = '0;
							end else if (s_r.b1 == OP_WR_DATA) begin
								s_nxt.st = ST_WRITE;
								s_nxt.addr = AW'(DATA_BASE) + AW'(s_r.b3);
								s_nxt.wdat = nb;
								s_nxt.limit = 18'(WR_CYC);
								s_nxt.tmr = '0;
							end
						end
					end
				endcase
			end else begin
				s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
			end
			// Read address is set up as soon as byte three is complete.
			if (s_r.bit_cnt == 3'h7 && s_r.byte_cnt == 2'h2
				&& s_r.st == ST_IDLE) begin
				s_nxt.addr = (s_r.b1 == OP_RD_DATA) ?
					AW'(DATA_BASE) + AW'(nb) : AW'(PROG_BASE) + AW'(nb);
			end
		end
		if (fall) begin
			if (s_r.byte_cnt == 2'h3 && s_r.bit_cnt == 3'h0) begin
				// Read data are loaded at this fall, not at the rise
				// before it, because the address only moved at that rise.
				s_nxt.sh_out = mem_rdat;
				s_nxt.sdo = mem_rdat[7];
			end else begin
				s_nxt.sdo = s_r.sh_out[7];
			end
		end
		// Parallel strobe starts a self-timed job.
		if (wr_fall && s_r.st == ST_IDLE) begin
			s_nxt.busy = 1'b1;
			s_nxt.tmr = '0;
			s_nxt.addr = s_r.adr_s1;
			s_nxt.wdat = s_r.dat_s1;
			if (s_r.cmd_s1 == PCMD_ERASE) begin
				s_nxt.st = ST_ERASE;
				s_nxt.addr = '0;
				s_nxt.limit = 18'(CE_CYC);
			end else begin
				s_nxt.st = ST_WRITE;
				s_nxt.limit = 18'(WR_CYC);
			end
		end
		unique case (s_r.st)
			ST_IDLE: ;
			ST_WRITE: begin
				// Auto-erase then program happen inside one write cycle.
				mem_we = 1'b1;
				s_nxt.st = ST_WAIT;
				s_nxt.tmr = s_r.tmr + 18'h1;
			end
			ST_ERASE: begin
				mem_we = 1'b1;
				mem_wdat = ERASED_BYTE;
				s_nxt.addr = s_r.addr + AW'(1);
				s_nxt.tmr = s_r.tmr + 18'h1;
				if (s_r.addr == AW'(MEM_WORDS - 1)) begin
					s_nxt.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				s_nxt.tmr = s_r.tmr + 18'h1;
				if (s_r.tmr >= s_r.limit - 18'h1) begin
					s_nxt.st = ST_IDLE;
					s_nxt.busy = 1'b0;
				end
			end
		endcase
		// Ready is kept in a flop of its own so the pin needs no gate.
		s_nxt.rdy = !s_nxt.busy;
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_r <= '{rst_s: 2'h3, sck_s: 2'h0, sdi_s: 2'h0, wr_s: 2'h3,
				wr_d: 1'b1, rdy: 1'b1, st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prog_serial_out_o = s_r.sdo;
	assign ready_busy_flag_o = s_r.rdy;
	assign prog_enabled_o = s_r.enabled;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_busy_fast: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		$fell(s_r.wr_s[1]) && s_r.st == ST_IDLE |=> !ready_busy_flag_o)
		else $error("busy not raised after strobe");
	a_no_early_op: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.st != ST_IDLE && $past(s_r.st) == ST_IDLE
		&& !$past(s_r.wr_s[1] == 1'b0)
		|-> $past(s_r.enabled))
		else $error("serial job before enable");
	a_drop_out_reset: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.rst_s[1] |=> !prog_enabled_o)
		else $error("enable kept outside reset");
	a_erase_ones: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.st == ST_ERASE |-> mem_we && mem_wdat == ERASED_BYTE)
		else $error("erase data not all ones");
	a_write_once: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.st == ST_WRITE |=> s_r.st == ST_WAIT && !mem_we)
		else $error("write cycle malformed");
	a_busy_min: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		$rose(ready_busy_flag_o) |-> $past(s_r.tmr) >= s_r.limit - 18'h1)
		else $error("busy released early");
	a_busy_max: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.busy |-> s_r.tmr <= 18'(CE_CYC_MAX))
		else $error("busy held too long");
	a_sdo_fall: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		$changed(prog_serial_out_o)
		|-> $past(s_r.sck_d) && !$past(s_r.sck_s[1]))
		else $error("output moved off falling edge");
	a_echo: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		s_r.byte_cnt == 2'h2 && s_r.bit_cnt == 3'h0 && $changed(s_r.byte_cnt)
		|-> s_r.sh_out == s_r.b2)
		else $error("second byte not loaded for echo");
	c_enable: cover property (@(posedge core_clk_i) $rose(prog_enabled_o));
	c_ser_write: cover property (@(posedge core_clk_i)
		s_r.st == ST_WRITE && s_r.addr >= AW'(DATA_BASE));
	c_erase: cover property (@(posedge core_clk_i) $rose(s_r.st == ST_ERASE));
	c_busy_done: cover property (@(posedge core_clk_i) $rose(ready_busy_flag_o));
endmodule
`default_nettype wire

// ### common/mpi_pkg.sv
package mpi_pkg;

	// Core clock rate in kHz and the self-timed limits in their own units.
	localparam int CLK_KHZ = 25000;
	localparam int T_BUSY_LOW_US = 1;
	localparam int T_WR_MIN_US = 3700;
	localparam int T_WR_MAX_US = 5000;
	localparam int T_CE_MIN_US = 7500;
	localparam int T_CE_MAX_US = 10000;
	// Cycle counts: busy set within the max, release between min and max.
	localparam int BUSY_LOW_CYC = (T_BUSY_LOW_US * CLK_KHZ) / 1000;
	localparam int WR_CYC_DEF = (T_WR_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int CE_CYC_DEF = (T_CE_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int WR_CYC_MAX = (T_WR_MAX_US * CLK_KHZ) / 1000;
	localparam int CE_CYC_MAX = (T_CE_MAX_US * CLK_KHZ) / 1000;

	// Serial instruction bytes and the erased byte value.
	localparam logic [7:0] OP_PREFIX = 8'hAC;
	localparam logic [7:0] OP_ENABLE = 8'h53;
	localparam logic [2:0] OP_ERASE_TOP = 3'h4;
	localparam logic [7:0] OP_RD_PROG = 8'h20;
	localparam logic [7:0] OP_WR_DATA = 8'hC0;
	localparam logic [7:0] OP_RD_DATA = 8'hA0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// Memory sizes: program and data arrays share one address space.
	localparam int AW = 9;
	localparam int PROG_BASE = 0;
	localparam int DATA_BASE = 256;
	localparam int MEM_WORDS = 512;

	// Parallel command codes taken at the write strobe.
	localparam logic [1:0] PCMD_WRITE = 2'h1;
	localparam logic [1:0] PCMD_ERASE = 2'h2;

endpackage

// ### hw/mpi_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mpi_mem
	import mpi_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [MEM_WORDS];

	// No reset on the array; erase is done word by word by the owner.
	always_ff @(posedge core_clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// ### tb/mpi_programmer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External serial programmer model
// ****************************************
module mpi_programmer (
	output logic sck_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// The serial clock stands low between frames.
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end

	// Every phase lasts 160 ns, four core cycles, so it is never too short.
	task automatic send(input logic [31:0] ins, output logic [31:0] rsp);
		for (int i = 31; i >= 0; i--) begin
			sdi_o = ins[i];
			#160;
			sck_o = 1'b1;
			#150;
			rsp[i] = sdo_i;
			#10;
			sck_o = 1'b0;
		end
		// A released data line must not keep showing the last bit.
		sdi_o = ~ins[0];
	endtask
endmodule
`default_nettype wire

// ### tb/memory_programming_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module memory_programming_interface_tb;
	import mpi_pkg::*;
	localparam int WR_T = 20;
	localparam int CE_T = 600;
	logic core_clk_i, reset_i, rst_pin_n, sck, sdi, wr_n, sdo, ready, enabled;
	logic [1:0] cmd;
	logic [AW-1:0] addr;
	logic [7:0] data;
	logic [31:0] rsp;
	int n_mismatch = 0;
	int n_tests = 0;

	mpi_prog #(.WR_CYC(WR_T), .CE_CYC(CE_T)) u_mpi_prog (
		.core_clk_i(core_clk_i), .reset_i(reset_i),
		.prog_reset_n_i(rst_pin_n), .sck_i(sck), .prog_serial_in_i(sdi),
		.par_wr_n_i(wr_n), .par_cmd_i(cmd), .par_addr_i(addr),
		.par_data_i(data), .prog_serial_out_o(sdo),
		.ready_busy_flag_o(ready), .prog_enabled_o(enabled));
	mpi_programmer u_mpi_programmer (.sck_o(sck), .sdi_o(sdi), .sdo_i(sdo));

	// ****************************************
	// Clock and shared tasks
	// ****************************************
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic ser(input logic [31:0] ins);
		u_mpi_programmer.send(ins, rsp);
		cyc(2);
	endtask

	task automatic rd(input logic [7:0] op, input logic [7:0] a);
		ser({op, 8'h00, a, 8'h00});
	endtask

	// Strobe falls at once; busy is timed from that fall in core cycles.
	task automatic par(input logic [1:0] c, input logic [AW-1:0] a,
		input logic [7:0] v, input int t);
		int m;
		m = 0;
		cmd = c;
		addr = a;
		data = v;
		wr_n = 1'b0;
		while (ready !== 1'b0 && m < BUSY_LOW_CYC) begin
			cyc(1);
			m++;
		end
		check(32'(ready), 32'h0);
		while (ready !== 1'b1 && m < t + 20) begin
			cyc(1);
			m++;
			if (m >= 4) wr_n = 1'b1;
		end
		wr_n = 1'b1;
		check(32'(m >= t && m <= t + 6), 32'h1);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_gate();
		check(32'({sdo, ready, enabled}), 32'h2);
		ser({OP_PREFIX, OP_ENABLE, 16'h0000});
		check(32'(enabled), 32'h0);
		rst_pin_n = 1'b0;
		cyc(5);
		ser({OP_PREFIX, OP_ENABLE, 16'h0000});
		check(32'(rsp[15:8]), 32'(OP_ENABLE));
		check(32'(enabled), 32'h1);
		$display("test gate done");
	endtask

	task automatic t_erase();
		ser({OP_PREFIX, 8'h9F, 16'h0000});
		cyc(CE_T + 10);
		rd(OP_RD_PROG, 8'h03);
		check(32'(rsp[7:0]), 32'(ERASED_BYTE));
		rd(OP_RD_DATA, 8'h05);
		check(32'(rsp[7:0]), 32'(ERASED_BYTE));
		$display("test erase done");
	endtask

	task automatic t_refuse();
		rst_pin_n = 1'b1;
		cyc(5);
		check(32'(enabled), 32'h0);
		rst_pin_n = 1'b0;
		cyc(5);
		ser({OP_WR_DATA, 8'h00, 8'h05, 8'h11});
		cyc(WR_T + 10);
		ser({OP_PREFIX, OP_ENABLE, 16'h0000});
		rd(OP_RD_DATA, 8'h05);
		check(32'(rsp[7:0]), 32'(ERASED_BYTE));
		$display("test refuse done");
	endtask

	// Overwriting 5A with 33 would read 12 if the old byte were not erased.
	task automatic t_autoerase(input logic [7:0] v);
		ser({OP_WR_DATA, 8'h00, 8'h05, v});
		cyc(WR_T + 10);
		rd(OP_RD_DATA, 8'h05);
		check(32'(rsp[7:0]), 32'(v));
		$display("test auto erase done");
	endtask

	task automatic t_par();
		par(PCMD_WRITE, AW'(DATA_BASE + 7), 8'h77, WR_T);
		rd(OP_RD_DATA, 8'h07);
		check(32'(rsp[7:0]), 32'h77);
		par(PCMD_ERASE, '0, 8'h00, CE_T);
		rd(OP_RD_DATA, 8'h07);
		check(32'(rsp[7:0]), 32'(ERASED_BYTE));
		$display("test parallel done");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The run needs about 5000 cycles; the limit leaves ample margin.
	initial begin
		repeat (30000) @(posedge core_clk_i);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		reset_i = 1'b1;
		rst_pin_n = 1'b1;
		wr_n = 1'b1;
		cmd = 2'h0;
		addr = '0;
		data = 8'h00;
		cyc(6);
		reset_i = 1'b0;
		cyc(4);
		t_gate();
		t_erase();
		t_refuse();
		t_autoerase(8'h5A);
		t_autoerase(8'h33);
		t_par();
		end_of_test();
	end
endmodule
`default_nettype wire
